//--- sim/test_timer2_waveform_control_a.sv
// Self-checking bench for the timer waveform block over APB.
// Assumes the design files and the pad model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module test_timer2_waveform_control_a;
  localparam int LIMIT = 60000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic oc_a, oe_a, own_a, oc_b, oe_b, own_b, pad_a, pad_b;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int reg_m [8];

  // Half-period inversion gives the 25 MHz clock.
  always #20 pclk = ~pclk;

  tw_timer #(.TICK_DIV(1)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .compare_out_a_pin(oc_a),
    .compare_out_a_oe(oe_a), .compare_out_a_own(own_a),
    .compare_out_b_pin(oc_b), .compare_out_b_oe(oe_b),
    .compare_out_b_own(own_b));
  tw_port_model pm_a (.own(own_a), .oe(oe_a), .oc(oc_a), .pad(pad_a));
  tw_port_model pm_b (.own(own_b), .oe(oe_b), .oc(oc_b), .pad(pad_b));

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // A hung handshake or wait is cut short here.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors = num_errors + 1;
      $display("ERROR timeout expected end seen %0d cycles", cycles);
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Writes also update the register model through the writable masks.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    logic [31:0] m;
    apb(1'b1, a, d, rd, e);
    case (a)
      tw_pkg::ADDR_CTRL_A: m = 32'(tw_pkg::CTRL_A_WMASK);
      tw_pkg::ADDR_CTRL_B: m = 32'(tw_pkg::CTRL_B_WMASK);
      tw_pkg::ADDR_IRQ_MASK: m = 32'(tw_pkg::IRQ_WMASK);
      tw_pkg::ADDR_PIN_DIR: m = 32'h3;
      default: m = 32'hFF;
    endcase
    reg_m[a[4:2]] = int'(d & m);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk(what, exp, rd);
    chk({what, " slverr"}, {31'h0, exp_err}, {31'h0, e});
  endtask : rdc

  // Counts high samples and changes on both pads over n cycles.
  task automatic measure(input int n, output int ha, output int hb,
                         output int ta, output int tb);
    logic pa, pb;
    ha = 0;
    hb = 0;
    ta = 0;
    tb = 0;
    @(negedge pclk);
    pa = pad_a;
    pb = pad_b;
    repeat (n) begin
      @(negedge pclk);
      ha = ha + int'(pad_a === 1'b1);
      hb = hb + int'(pad_b === 1'b1);
      ta = ta + int'(pad_a !== pa);
      tb = tb + int'(pad_b !== pb);
      pa = pad_a;
      pb = pad_b;
    end
  endtask : measure

  // Stops, loads and restarts the counter; reserved bits are written too.
  task automatic cfg(input int mode, input int com, input int va,
                     input int vb);
    wr(tw_pkg::ADDR_CTRL_B, 32'(mode >> 2));
    wr(tw_pkg::ADDR_COUNT, 32'h0);
    wr(tw_pkg::ADDR_CMP_A, 32'(va));
    wr(tw_pkg::ADDR_CMP_B, 32'(vb));
    wr(tw_pkg::ADDR_CTRL_A, 32'((com << 6) | (com << 4) | 12 | (mode & 3)));
    rdc("control a", tw_pkg::ADDR_CTRL_A, 32'(reg_m[0]), 1'b0);
    wr(tw_pkg::ADDR_CTRL_B, 32'((mode >> 2) | 2));
  endtask : cfg

  // Model: high ticks in one PWM period for a compare value d.
  function automatic int exp_high(input int mode, input int com,
                                  input int d, input int top);
    if (mode == 3 || mode == 7) begin
      return (com == 2) ? d + 1 : top - d;
    end
    return (com == 2) ? 2 * d : 2 * (top - d);
  endfunction : exp_high

  // Runs one PWM setting for two whole periods after settling.
  task automatic pwm(input int mode, input int com, input int va,
                     input int vb, input int top);
    int per, ha, hb, ta, tb;
    per = (mode == 3 || mode == 7) ? top + 1 : 2 * top;
    cfg(mode, com, va, vb);
    // A stale active compare value may last one whole 256-tick count.
    repeat (2 * per + 264) @(posedge pclk);
    measure(2 * per, ha, hb, ta, tb);
    if (com == 1) begin
      chk("toggles a", 32'((mode >> 2) * 2), 32'(ta));
      chk("toggles b", 32'h0, 32'(tb));
    end else begin
      ta = 2 * exp_high(mode, com, va, top);
      tb = 2 * exp_high(mode, com, vb, top);
      if (mode < 4) begin
        chk("high a", 32'(ta), 32'(ha));
      end
      chk("high b", 32'(tb), 32'(hb));
    end
  endtask : pwm

  // Main sequence: reset, registers, waveforms, then flags.
  initial begin
    int ha, hb, ta, tb, d, t, m;
    logic [31:0] rd;
    logic e;
    void'($urandom(965));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rdc("reset reg", 8'(4 * i), 32'h0, 1'b0);
    end
    chk("own a reset", 32'h0, {31'h0, own_a});
    rdc("unmapped", 8'h20, 32'h0, 1'b1);
    wr(tw_pkg::ADDR_CTRL_A, 32'hFF);
    rdc("control a", tw_pkg::ADDR_CTRL_A, 32'hF3, 1'b0);
    chk("own b", 32'h1, {31'h0, own_b});
    chk("oe a off", 32'h0, {31'h0, oe_a});
    wr(tw_pkg::ADDR_PIN_DIR, 32'h3);
    // The write lands at the edge that ends the task, so wait one more.
    @(posedge pclk);
    chk("oe a on", 32'h1, {31'h0, oe_a});
    wr(tw_pkg::ADDR_IRQ_MASK, 32'h1);
    $display("register test done");
    for (int c = 1; c < 4; c++) begin
      for (m = 0; m < 3; m = m + 2) begin
        t = (m == 2) ? 19 : 255;
        cfg(m, c, t, 5);
        repeat (t + 10) @(posedge pclk);
        measure(2 * (t + 1), ha, hb, ta, tb);
        d = (c == 1) ? 2 : (c - 2) * 2 * (t + 1);
        chk("match a", 32'(d), 32'((c == 1) ? ta : ha));
        chk("match b", 32'(d), 32'((c == 1) ? tb : hb));
      end
    end
    $display("non-pwm test done");
    for (int c = 1; c < 4; c++) begin
      d = $urandom_range(250, 1);
      pwm(3, c, d, $urandom_range(250, 1), 255);
      pwm(1, c, d, $urandom_range(250, 1), 255);
      t = $urandom_range(150, 60);
      pwm(7, c, t, $urandom_range(50, 1), t);
      pwm(5, c, t, $urandom_range(50, 1), t);
    end
    pwm(3, 2, 255, 255, 255);
    pwm(1, 3, 255, 255, 255);
    $display("pwm test done");
    for (m = 0; m < 8; m++) begin
      cfg(m, 0, 8'h80, 8'h10);
      repeat (600) @(posedge pclk);
      wr(tw_pkg::ADDR_CTRL_B, 32'(m >> 2));
      // Clear on match wraps at compare A below MAX, so it never overflows.
      t = (m == 2 || m == 4 || m == 6) ? 0 : 1;
      chk("irq", 32'(t), {31'h0, irq});
      apb(1'b0, tw_pkg::ADDR_IRQ_STAT, 32'h0, rd, e);
      chk("overflow flag", 32'(t), rd & 32'h1);
      rdc("status cleared", tw_pkg::ADDR_IRQ_STAT, 32'h0, 1'b0);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    wr(tw_pkg::ADDR_IRQ_MASK, 32'h0);
    cfg(0, 0, 8'h80, 8'h10);
    repeat (600) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("flag test done");
    finish_test();
  end
endmodule : test_timer2_waveform_control_a
`default_nettype wire

//--- sim/tw_port_model.sv
// Pad model for one port pin that a compare output can take over.
// Assumes the pin has a weak pull-up and no other driver in this bench.
`timescale 1ns/1ns
`default_nettype none
module tw_port_model (
  input wire logic own,
  input wire logic oe,
  input wire logic oc,
  output logic pad
);
  // The driver stays off until the direction bit is set, so the pull-up wins.
  assign pad = (own && oe) ? oc : 1'b1;
endmodule : tw_port_model
`default_nettype wire

//--- verilog/tw_channel.sv
// One compare output channel: turns match and turn-around events into a pin.
// Assumes events arrive as one-cycle pulses from the counter in tw_timer.
`timescale 1ns/1ns
`default_nettype none
module tw_channel #(
  parameter bit ALLOW_TOGGLE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] com,
  input wire tw_pkg::tw_cls_e cls,
  input wire logic hi,
  input wire logic match,
  input wire logic top_hit,
  input wire logic up,
  input wire logic eq_top,
  output logic oc
);
  typedef struct packed {
    logic oc;
  } tw_chan_s;

  tw_chan_s st_ff;
  tw_chan_s nxt_st;
  logic tgl_ok;

  // Toggle in PWM classes needs the mode high bit and a channel that has it.
  assign tgl_ok = ALLOW_TOGGLE && hi;

  // Output level decision; the turn-around event wins over a plain match.
  always_comb begin
    nxt_st = st_ff;
    case (cls)
      tw_pkg::CLS_NONPWM: begin
        if (match) begin
          case (com)
            tw_pkg::COM_TGL: nxt_st.oc = !st_ff.oc;
            tw_pkg::COM_CLR: nxt_st.oc = 1'b0;
            tw_pkg::COM_SET: nxt_st.oc = 1'b1;
            default: nxt_st.oc = st_ff.oc;
          endcase
        end
      end
      tw_pkg::CLS_FAST: begin
        if (com == tw_pkg::COM_TGL) begin
          if (tgl_ok && match) begin
            nxt_st.oc = !st_ff.oc;
          end
        end else if (com[1]) begin
          if (top_hit) begin
            nxt_st.oc = !com[0];
          end else if (match && !eq_top) begin
            nxt_st.oc = com[0];
          end
        end
      end
      tw_pkg::CLS_PHASE: begin
        if (com == tw_pkg::COM_TGL) begin
          if (tgl_ok && match) begin
            nxt_st.oc = !st_ff.oc;
          end
        end else if (com[1]) begin
          if (eq_top) begin
            if (top_hit) begin
              nxt_st.oc = !com[0];
            end
          end else if (match) begin
            nxt_st.oc = up ? com[0] : !com[0];
          end
        end
      end
      default: nxt_st = st_ff;
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign oc = st_ff.oc;

  property p_nonpwm_clr;
    @(posedge pclk) disable iff (!presetn)
    (cls == tw_pkg::CLS_NONPWM) && match && (com == tw_pkg::COM_CLR)
      |=> !oc;
  endproperty
  a_nonpwm_clr: assert property (p_nonpwm_clr)
    else $error("clear on match did not clear the output");

  property p_fast_bottom;
    @(posedge pclk) disable iff (!presetn)
    (cls == tw_pkg::CLS_FAST) && com[1] && top_hit |=> oc == !$past(com[0]);
  endproperty
  a_fast_bottom: assert property (p_fast_bottom)
    else $error("fast PWM output wrong after BOTTOM");

  property p_phase_top;
    @(posedge pclk) disable iff (!presetn)
    (cls == tw_pkg::CLS_PHASE) && com[1] && eq_top && top_hit
      |=> oc == !$past(com[0]);
  endproperty
  a_phase_top: assert property (p_phase_top)
    else $error("phase correct output wrong at TOP");

  property p_no_toggle;
    @(posedge pclk) disable iff (!presetn)
    (cls != tw_pkg::CLS_NONPWM) && (com == tw_pkg::COM_TGL) && !tgl_ok
      |=> $stable(oc);
  endproperty
  a_no_toggle: assert property (p_no_toggle)
    else $error("output moved while toggle is not allowed");
endmodule : tw_channel
`default_nettype wire

//--- verilog/tw_pkg.sv
// Constants, field positions and mode decoding for the timer waveform block.
// Assumes a 32-bit APB slave with byte addresses and one aligned word each.
// Overview of operation
// - A nonzero compare output mode field hands the pin to the channel.
// - Channel A non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Channel A fast PWM: 01 toggles only with high bit; 1x match/BOTTOM.
// - Fast PWM with compare equal TOP ignores match, still acts at BOTTOM.
// - Channel A phase correct: 01 toggles with high bit; 1x up/down matches.
// - Phase correct with compare equal TOP ignores match, acts at TOP.
// - Channel B non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Channel B fast PWM: 01 reserved, 10 non-inverting, 11 inverting.
// - Channel B phase correct: 01 reserved, 10 clear up/set down, 11 inverse.
// - Control bits 3:2 are reserved and always read as zero.
// - Waveform mode picks counting, TOP 0xFF or compare value A, per mode.
// - Compare values apply at once, at TOP, or at BOTTOM by mode class.
// - Overflow flag sets at MAX, BOTTOM or TOP depending on mode.
`default_nettype none
package tw_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_CMP_A = 8'h0C;
  localparam logic [7:0] ADDR_CMP_B = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_PIN_DIR = 8'h1C;

  // Field positions inside the control, interrupt status and interrupt mask registers.
  localparam int CMA_MSB = 7;
  localparam int CMA_LSB = 6;
  localparam int CMB_MSB = 5;
  localparam int CMB_LSB = 4;
  localparam int WML_MSB = 1;
  localparam int WML_LSB = 0;
  localparam int HI_BIT = 0;
  localparam int RUN_BIT = 1;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_CMA = 1;
  localparam int IRQ_CMB = 2;

  // Writable masks, the control reset value and the counter's MAX and BOTTOM.
  localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
  localparam logic [1:0] CTRL_B_WMASK = 2'h3;
  localparam logic [2:0] IRQ_WMASK = 3'h7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;

  // Waveform mode codes, high bit first.
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PHASE_FF = 3'h1;
  localparam logic [2:0] WM_MATCH_CLR = 3'h2;
  localparam logic [2:0] WM_FAST_FF = 3'h3;
  localparam logic [2:0] WM_PHASE_A = 3'h5;
  localparam logic [2:0] WM_FAST_A = 3'h7;

  // Compare output mode codes.
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TGL = 2'h1;
  localparam logic [1:0] COM_CLR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  typedef enum logic [1:0] {
    CLS_NONPWM = 2'b00,
    CLS_FAST = 2'b01,
    CLS_PHASE = 2'b10,
    CLS_RSVD = 2'b11
  } tw_cls_e;

  // Sorts a waveform mode into its counting class.
  function automatic tw_cls_e wave_class(input logic [2:0] mode);
    case (mode)
      WM_NORMAL, WM_MATCH_CLR: wave_class = CLS_NONPWM;
      WM_FAST_FF, WM_FAST_A: wave_class = CLS_FAST;
      WM_PHASE_FF, WM_PHASE_A: wave_class = CLS_PHASE;
      default: wave_class = CLS_RSVD;
    endcase
  endfunction : wave_class

  // True where compare value A is the top of the count.
  function automatic logic top_is_a(input logic [2:0] mode);
    top_is_a = (mode == WM_MATCH_CLR) || (mode == WM_PHASE_A) ||
      (mode == WM_FAST_A);
  endfunction : top_is_a
endpackage : tw_pkg
`default_nettype wire

//--- verilog/tw_timer.sv
// Top of the 8-bit timer with waveform control, reached over APB.
// Assumes pclk at 25 MHz, a zero-wait APB master and port logic outside.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module tw_timer #(
  parameter int TICK_DIV = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic compare_out_a_pin,
  output logic compare_out_a_oe,
  output logic compare_out_a_own,
  output logic compare_out_b_pin,
  output logic compare_out_b_oe,
  output logic compare_out_b_own
);
  localparam logic [15:0] DIV_LAST = 16'(TICK_DIV - 1);

  // The divider counter is 16 bits wide, so larger ratios cannot be served.
  if (TICK_DIV < 1 || TICK_DIV > 65536) begin : g_bad_div
    $error("TICK_DIV must lie between 1 and 65536");
  end

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [1:0] ctrl_b;
    logic [7:0] cnt;
    logic dn;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [7:0] ocr_a;
    logic [7:0] ocr_b;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [1:0] pin_dir;
    logic [7:0] rdata;
    logic [15:0] div;
  } tw_top_s;

  tw_top_s st_ff;
  tw_top_s nxt_st;

  logic [2:0] wave_mode;
  tw_pkg::tw_cls_e cls;
  logic [7:0] top;
  logic tick;
  logic top_hit;
  logic at_max;
  logic at_bot;
  logic match_a;
  logic match_b;
  logic ovf_ev;
  logic acc;
  logic wr;
  logic [2:0] clr;
  logic oc_a;
  logic oc_b;

  // Address decode for the error answer; the read mux decodes the address itself.
  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      tw_pkg::ADDR_CTRL_A, tw_pkg::ADDR_CTRL_B, tw_pkg::ADDR_COUNT,
      tw_pkg::ADDR_CMP_A, tw_pkg::ADDR_CMP_B, tw_pkg::ADDR_IRQ_STAT,
      tw_pkg::ADDR_IRQ_MASK, tw_pkg::ADDR_PIN_DIR: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Read mux; compare registers read back the value software last wrote.
  function automatic logic [7:0] rd_mux(input logic [7:0] addr,
                                        input tw_top_s s);
    case (addr)
      tw_pkg::ADDR_CTRL_A: rd_mux = s.ctrl_a & tw_pkg::CTRL_A_WMASK;
      tw_pkg::ADDR_CTRL_B: rd_mux = {6'h00, s.ctrl_b};
      tw_pkg::ADDR_COUNT: rd_mux = s.cnt;
      tw_pkg::ADDR_CMP_A: rd_mux = s.buf_a;
      tw_pkg::ADDR_CMP_B: rd_mux = s.buf_b;
      tw_pkg::ADDR_IRQ_STAT: rd_mux = {5'h00, s.stat};
      tw_pkg::ADDR_IRQ_MASK: rd_mux = {5'h00, s.mask};
      tw_pkg::ADDR_PIN_DIR: rd_mux = {6'h00, s.pin_dir};
      default: rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  // Mode decode and the counter's reference points.
  assign wave_mode = {st_ff.ctrl_b[tw_pkg::HI_BIT],
                      st_ff.ctrl_a[tw_pkg::WML_MSB:tw_pkg::WML_LSB]};
  assign cls = tw_pkg::wave_class(wave_mode);
  assign top = tw_pkg::top_is_a(wave_mode) ? st_ff.ocr_a : tw_pkg::CNT_MAX;
  assign tick = st_ff.ctrl_b[tw_pkg::RUN_BIT] && (st_ff.div == DIV_LAST);
  assign top_hit = tick && (st_ff.cnt == top);
  assign at_max = st_ff.cnt == tw_pkg::CNT_MAX;
  assign at_bot = st_ff.cnt == tw_pkg::CNT_BOTTOM;
  assign match_a = tick && (st_ff.cnt == st_ff.ocr_a);
  assign match_b = tick && (st_ff.cnt == st_ff.ocr_b);
  assign acc = psel && penable;
  assign wr = acc && pwrite;

  // Overflow event by mode; the reserved modes stop the counter instead.
  always_comb begin
    case (cls)
      tw_pkg::CLS_NONPWM: ovf_ev = tick && at_max;
      tw_pkg::CLS_FAST: begin
        if (wave_mode == tw_pkg::WM_FAST_A) begin
          ovf_ev = top_hit;
        end else begin
          ovf_ev = tick && at_max;
        end
      end
      tw_pkg::CLS_PHASE: ovf_ev = tick && st_ff.dn && at_bot;
      default: ovf_ev = 1'b0;
    endcase
  end

  // A status read clears only the bits it returned, so a flag raised
  // between the setup and access phases is kept for the next read.
  always_comb begin
    if (acc && !pwrite && (paddr == tw_pkg::ADDR_IRQ_STAT)) begin
      clr = st_ff.rdata[2:0];
    end else begin
      clr = 3'h0;
    end
  end

  // Next state of the whole block.
  always_comb begin
    nxt_st = st_ff;

    // Prescale divider, held at zero while the timer is stopped.
    if (!st_ff.ctrl_b[tw_pkg::RUN_BIT] || (st_ff.div == DIV_LAST)) begin
      nxt_st.div = 16'h0000;
    end else begin
      nxt_st.div = st_ff.div + 16'h0001;
    end

    // Counting sequence per waveform mode.
    if (tick) begin
      case (cls)
        tw_pkg::CLS_NONPWM: begin
          if (tw_pkg::top_is_a(wave_mode) && (st_ff.cnt == top)) begin
            nxt_st.cnt = tw_pkg::CNT_BOTTOM;
          end else begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
          end
        end
        tw_pkg::CLS_FAST: begin
          if (st_ff.cnt == top) begin
            nxt_st.cnt = tw_pkg::CNT_BOTTOM;
          end else begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
          end
        end
        tw_pkg::CLS_PHASE: begin
          if (top == tw_pkg::CNT_BOTTOM) begin
            nxt_st.cnt = tw_pkg::CNT_BOTTOM;
          end else if (!st_ff.dn && (st_ff.cnt == top)) begin
            nxt_st.dn = 1'b1;
            nxt_st.cnt = st_ff.cnt - 8'h01;
          end else if (st_ff.dn && at_bot) begin
            nxt_st.dn = 1'b0;
            nxt_st.cnt = st_ff.cnt + 8'h01;
          end else if (st_ff.dn) begin
            nxt_st.cnt = st_ff.cnt - 8'h01;
          end else begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
          end
        end
        default: nxt_st.cnt = st_ff.cnt;
      endcase
    end
    if (cls != tw_pkg::CLS_PHASE) begin
      nxt_st.dn = 1'b0;
    end

    // Compare values move from the written copy into the active copy.
    case (cls)
      tw_pkg::CLS_FAST, tw_pkg::CLS_PHASE: begin
        if (top_hit) begin
          nxt_st.ocr_a = st_ff.buf_a;
          nxt_st.ocr_b = st_ff.buf_b;
        end
      end
      default: begin
        nxt_st.ocr_a = st_ff.buf_a;
        nxt_st.ocr_b = st_ff.buf_b;
      end
    endcase

    // Sticky flags; a new event wins over the clear of a read.
    nxt_st.stat = (st_ff.stat & ~clr) | {match_b, match_a, ovf_ev};

    // Register writes complete in the access phase.
    if (wr) begin
      case (paddr)
        tw_pkg::ADDR_CTRL_A: begin
          nxt_st.ctrl_a = pwdata[7:0] & tw_pkg::CTRL_A_WMASK;
        end
        tw_pkg::ADDR_CTRL_B: begin
          nxt_st.ctrl_b = pwdata[1:0] & tw_pkg::CTRL_B_WMASK;
        end
        tw_pkg::ADDR_COUNT: nxt_st.cnt = pwdata[7:0];
        tw_pkg::ADDR_CMP_A: nxt_st.buf_a = pwdata[7:0];
        tw_pkg::ADDR_CMP_B: nxt_st.buf_b = pwdata[7:0];
        tw_pkg::ADDR_IRQ_MASK: nxt_st.mask = pwdata[2:0] & tw_pkg::IRQ_WMASK;
        tw_pkg::ADDR_PIN_DIR: nxt_st.pin_dir = pwdata[1:0];
        default: nxt_st.pin_dir = st_ff.pin_dir;
      endcase
    end

    // Read data is caught in the setup phase and held through the access.
    if (psel && !penable) begin
      nxt_st.rdata = rd_mux(paddr, st_ff);
    end
  end

  // State register; everything resets to zero, which is normal mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Channel A has the toggle option under PWM; channel B has it reserved.
  tw_channel #(
    .ALLOW_TOGGLE(1'b1)
  ) u_chan_a (
    .pclk(pclk),
    .presetn(presetn),
    .com(st_ff.ctrl_a[tw_pkg::CMA_MSB:tw_pkg::CMA_LSB]),
    .cls(cls),
    .hi(st_ff.ctrl_b[tw_pkg::HI_BIT]),
    .match(match_a),
    .top_hit(top_hit),
    .up(!st_ff.dn),
    .eq_top(st_ff.ocr_a == top),
    .oc(oc_a)
  );

  tw_channel #(
    .ALLOW_TOGGLE(1'b0)
  ) u_chan_b (
    .pclk(pclk),
    .presetn(presetn),
    .com(st_ff.ctrl_a[tw_pkg::CMB_MSB:tw_pkg::CMB_LSB]),
    .cls(cls),
    .hi(st_ff.ctrl_b[tw_pkg::HI_BIT]),
    .match(match_b),
    .top_hit(top_hit),
    .up(!st_ff.dn),
    .eq_top(st_ff.ocr_b == top),
    .oc(oc_b)
  );

  // Bus answers; the slave never inserts wait states.
  assign prdata = {24'h000000, st_ff.rdata};
  assign pready = 1'b1;
  assign pslverr = acc && !is_mapped(paddr);
  assign irq = |(st_ff.stat & st_ff.mask);

  // Pin ownership follows the mode field; the driver also needs direction.
  assign compare_out_a_own = |st_ff.ctrl_a[tw_pkg::CMA_MSB:tw_pkg::CMA_LSB];
  assign compare_out_b_own = |st_ff.ctrl_a[tw_pkg::CMB_MSB:tw_pkg::CMB_LSB];
  assign compare_out_a_oe = compare_out_a_own && st_ff.pin_dir[0];
  assign compare_out_b_oe = compare_out_b_own && st_ff.pin_dir[1];
  assign compare_out_a_pin = oc_a;
  assign compare_out_b_pin = oc_b;

  // Checks on the register interface, the counter and the flags.
  property p_own_a;
    @(posedge pclk) disable iff (!presetn)
    wr && (paddr == tw_pkg::ADDR_CTRL_A) && (pwdata[7:6] != 2'b00)
      |=> compare_out_a_own;
  endproperty
  a_own_a: assert property (p_own_a)
    else $error("nonzero mode field did not take the pin");

  property p_rsvd_read;
    @(posedge pclk) disable iff (!presetn)
    acc && !pwrite && (paddr == tw_pkg::ADDR_CTRL_A) |-> prdata[3:2] == 2'b00;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved control bits read nonzero");

  property p_rsvd_write;
    @(posedge pclk) disable iff (!presetn)
    wr && (paddr == tw_pkg::ADDR_CTRL_A)
      |=> st_ff.ctrl_a == ($past(pwdata[7:0]) & tw_pkg::CTRL_A_WMASK);
  endproperty
  a_rsvd_write: assert property (p_rsvd_write)
    else $error("control write stored the wrong value");

  property p_clr_wrap;
    @(posedge pclk) disable iff (!presetn)
    tick && (wave_mode == tw_pkg::WM_MATCH_CLR) &&
      (st_ff.cnt == st_ff.ocr_a) && !(wr && (paddr == tw_pkg::ADDR_COUNT))
      |=> st_ff.cnt == 8'h00;
  endproperty
  a_clr_wrap: assert property (p_clr_wrap)
    else $error("clear on match mode did not wrap at compare A");

  property p_fast_hold;
    @(posedge pclk) disable iff (!presetn)
    (cls == tw_pkg::CLS_FAST) && !top_hit ##1 (cls == tw_pkg::CLS_FAST)
      |-> st_ff.ocr_a == $past(st_ff.ocr_a);
  endproperty
  a_fast_hold: assert property (p_fast_hold)
    else $error("fast PWM compare value changed away from BOTTOM");

  property p_ovf_max;
    @(posedge pclk) disable iff (!presetn)
    tick && (wave_mode == tw_pkg::WM_NORMAL) && at_max
      |=> st_ff.stat[tw_pkg::IRQ_OVF];
  endproperty
  a_ovf_max: assert property (p_ovf_max)
    else $error("overflow flag not set at MAX");

  property p_ovf_phase;
    @(posedge pclk) disable iff (!presetn)
    tick && (cls == tw_pkg::CLS_PHASE) && st_ff.dn && at_bot
      |=> st_ff.stat[tw_pkg::IRQ_OVF] ##1
      (st_ff.stat[tw_pkg::IRQ_OVF] || $past(clr[0]));
  endproperty
  a_ovf_phase: assert property (p_ovf_phase)
    else $error("overflow flag not set at BOTTOM in phase correct");

  property p_phase_hold;
    @(posedge pclk) disable iff (!presetn)
    (cls == tw_pkg::CLS_PHASE) && !top_hit ##1 (cls == tw_pkg::CLS_PHASE)
      |-> st_ff.ocr_b == $past(st_ff.ocr_b);
  endproperty
  a_phase_hold: assert property (p_phase_hold)
    else $error("phase correct compare value changed away from TOP");
endmodule : tw_timer
`default_nettype wire
